//--- shifs_map.vh
/*
 * constants for the steering home/interlock fault supervisor: register offsets,
 * field positions, reset values, flash and sub codes, timing counts.
 * assumes a 100 MHz system clock and a 32-bit classic wishbone register port.
 */
`ifndef SHIFS_MAP_VH
`define SHIFS_MAP_VH

// ****************************************
// register byte offsets
// ****************************************
`define SHIFS_REG_CFG 8'h00
`define SHIFS_REG_PCHG 8'h04
`define SHIFS_REG_FAULT 8'h08
`define SHIFS_REG_CODE 8'h0c
`define SHIFS_REG_IRQ_STAT 8'h10
`define SHIFS_REG_IRQ_MASK 8'h14
`define SHIFS_REG_HOME_POS 8'h18
`define SHIFS_REG_TOL 8'h1c
`define SHIFS_REG_TMO 8'h20

// ****************************************
// cfg fields
// ****************************************
`define SHIFS_CFG_ILK_LSB 0
`define SHIFS_CFG_HOME_LSB 2
`define SHIFS_CFG_FULL_TURN_BIT 4
`define SHIFS_CFG_RST 32'h0000_0000

// ****************************************
// parameter change request bits (pchg)
// ****************************************
`define SHIFS_PCHG_CHANGED_BIT 0
`define SHIFS_PCHG_APPLOAD_BIT 1
`define SHIFS_PCHG_RANGE_BIT 2

// ****************************************
// fault bit positions
// ****************************************
`define SHIFS_F_PCHG 0
`define SHIFS_F_ILK 1
`define SHIFS_F_HSW 2
`define SHIFS_F_NOHOME 3
`define SHIFS_F_HREF 4

// ****************************************
// codes and modes
// ****************************************
`define SHIFS_FLASH_PCHG 8'h31
`define SHIFS_FLASH_ILK 8'h33
`define SHIFS_FLASH_HSW 8'h34
`define SHIFS_FLASH_NOHOME 8'h35
`define SHIFS_FLASH_HREF 8'h36
`define SHIFS_SUB_CODE 8'h01
`define SHIFS_ILK_CROSSED 2'h2
`define SHIFS_HOME_CROSSED 2'h1
`define SHIFS_HOME_SAME 2'h2
`define SHIFS_STATE_HOMING 3'h2
`define SHIFS_STATE_STEER 3'h4

// ****************************************
// travel limits, position unit 0.1 degree
// ****************************************
`define SHIFS_HALF_TRAVEL 16'h0708
`define SHIFS_FULL_TRAVEL 16'h0e10

// ****************************************
// timing
// ****************************************
`define SHIFS_CLK_MHZ 100
`define SHIFS_TICK_US 1000
`define SHIFS_TICK_CYC (`SHIFS_CLK_MHZ * `SHIFS_TICK_US)
`define SHIFS_TMO_RST 32'h0000_1388
`define SHIFS_TOL_RST 32'h0000_0032

`endif

//--- shifs_supervisor.v
/*
 * steering home/interlock fault supervisor: latches parameter change,
 * home switch, home not found and home drift faults, follows the unlatched interlock fault, with flash and
 * sub codes; classic wishbone slave with sticky status and mask interrupt.
 * assumes inputs synchronous to clk_i and rst_i asserted at key-switch power-up.
 */
// Added by the designer: the Wishbone slave port and the register addresses.
// Overview of operation
// - parameter needing power cycle changed raises fault 49 sub 1.
// - new application overwriting stored parameters raises fault 49.
// - serial unit requesting out-of-range parameter raises fault 49.
// - fault 49 stays latched until key-switch power is cycled.
// - interlock inputs one and three equal raises fault 51 sub 1.
// - interlock check only when type is crossed; clears once inputs differ.
// - homing type 1, home switches equal, beyond tolerance raises fault 52.
// - homing type 2, home switches differ, beyond tolerance raises fault 52.
// - homing state, home not found in 180/360 degrees or timeout raises 53.
// - steering state, home edge beyond tolerance from homed position raises 54.
`timescale 1ns/10ps
`include "shifs_map.vh"

module shifs_supervisor #(
  parameter TICK_CYC = `SHIFS_TICK_CYC,
  parameter POS_W = 16
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  // switches and position
  input wire interlock_a_i,
  input wire interlock_c_i,
  input wire home_sense_a_i,
  input wire home_sense_b_i,
  input wire home_i,
  input wire [POS_W-1:0] wheel_pos_i,
  input wire [2:0] steer_state_i,
  // fault report
  output reg [4:0] fault_o,
  output reg [7:0] flash_code_o,
  output reg [7:0] sub_code_o,
  output wire irq_o
);

  // ****************************************
  // helpers
  // ****************************************
  function [POS_W-1:0] absdiff;
    input [POS_W-1:0] a;
    input [POS_W-1:0] b;
    begin
      absdiff = (a > b) ? (a - b) : (b - a);
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] sel;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (sel[k]) begin
          merge[k*8 +: 8] = data[k*8 +: 8];
        end
      end
    end
  endfunction

  // ****************************************
  // registers
  // ****************************************
  reg [31:0] cfg;
  reg [31:0] tol;
  reg [31:0] tmo;
  reg [4:0] irq_stat;
  reg [4:0] irq_mask;
  reg [POS_W-1:0] home_pos;
  reg home_valid;
  reg home_q;
  reg [POS_W-1:0] homing_start;
  reg homing_active;
  reg [31:0] tick_cnt;
  reg [31:0] ms_cnt;
  reg [2:0] pchg_req;
  reg ms_tick;

  wire bus_req;
  wire wr;
  wire rd;
  assign bus_req = cyc_i & stb_i & ~ack_o;
  assign wr = bus_req & we_i;
  assign rd = bus_req & ~we_i;

  wire [1:0] ilk_type;
  wire [1:0] home_type;
  wire full_turn;
  wire [POS_W-1:0] tol_w;
  assign ilk_type = cfg[`SHIFS_CFG_ILK_LSB +: 2];
  assign home_type = cfg[`SHIFS_CFG_HOME_LSB +: 2];
  assign full_turn = cfg[`SHIFS_CFG_FULL_TURN_BIT];
  assign tol_w = tol[POS_W-1:0];

  // ****************************************
  // fault conditions
  // ****************************************
  wire [POS_W-1:0] off_home;
  wire beyond_tol;
  wire ilk_bad;
  wire hsw_bad;
  wire [POS_W-1:0] travel;
  wire [POS_W-1:0] travel_lim;
  wire homing;
  wire nohome_bad;
  wire home_edge;
  wire href_bad;
  wire pchg_bad;

  assign off_home = absdiff(wheel_pos_i, home_pos);
  // switch check only once home is known, the tolerance means nothing before
  assign beyond_tol = home_valid & (off_home > tol_w);
  assign ilk_bad = (ilk_type == `SHIFS_ILK_CROSSED) & (interlock_a_i == interlock_c_i);
  assign hsw_bad = beyond_tol &
    (((home_type == `SHIFS_HOME_CROSSED) & (home_sense_a_i == home_sense_b_i)) |
     ((home_type == `SHIFS_HOME_SAME) & (home_sense_a_i != home_sense_b_i)));
  assign travel = absdiff(wheel_pos_i, homing_start);
  assign travel_lim = full_turn ? `SHIFS_FULL_TRAVEL : `SHIFS_HALF_TRAVEL;
  assign homing = (steer_state_i == `SHIFS_STATE_HOMING);
  assign nohome_bad = homing & homing_active & ~home_valid &
    ((travel > travel_lim) | (ms_cnt >= tmo));
  assign home_edge = home_i ^ home_q;
  assign href_bad = (steer_state_i == `SHIFS_STATE_STEER) & home_valid & home_edge &
    (off_home > tol_w);
  assign pchg_bad = |pchg_req;

  wire [4:0] next_fault;
  assign next_fault[`SHIFS_F_PCHG] = fault_o[`SHIFS_F_PCHG] | pchg_bad;
  assign next_fault[`SHIFS_F_ILK] = ilk_bad;
  assign next_fault[`SHIFS_F_HSW] = fault_o[`SHIFS_F_HSW] | hsw_bad;
  assign next_fault[`SHIFS_F_NOHOME] = fault_o[`SHIFS_F_NOHOME] | nohome_bad;
  assign next_fault[`SHIFS_F_HREF] = fault_o[`SHIFS_F_HREF] | href_bad;

  wire [4:0] rise = next_fault & ~fault_o;

  // ****************************************
  // homing tracking and timeout
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt <= 32'h0000_0000;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= 1'b0;
      // restart on homing entry so the first millisecond is a full one
      if (homing & ~homing_active) begin
        tick_cnt <= 32'h0000_0000;
      end else if (tick_cnt == TICK_CYC - 1) begin
        tick_cnt <= 32'h0000_0000;
        ms_tick <= 1'b1;
      end else begin
        tick_cnt <= tick_cnt + 32'h0000_0001;
      end
    end
  end

  // ****************************************
  // home search state
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      home_q <= 1'b0;
      home_valid <= 1'b0;
      home_pos <= {POS_W{1'b0}};
      homing_start <= {POS_W{1'b0}};
      homing_active <= 1'b0;
      ms_cnt <= 32'h0000_0000;
    end else begin
      home_q <= home_i;
      if (homing & ~homing_active) begin
        homing_active <= 1'b1;
        homing_start <= wheel_pos_i;
        home_valid <= 1'b0;
        ms_cnt <= 32'h0000_0000;
      end else if (homing) begin
        // home found on the first home edge during homing
        if (home_edge & ~home_valid) begin
          home_valid <= 1'b1;
          home_pos <= wheel_pos_i;
        end
        // saturating: a stuck timer must never wrap back under the limit
        if (ms_tick && ms_cnt != 32'hffff_ffff) begin
          ms_cnt <= ms_cnt + 32'h0000_0001;
        end
      end else begin
        homing_active <= 1'b0;
      end
    end
  end

  // ****************************************
  // fault latches and report
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      fault_o <= 5'h00;
      flash_code_o <= 8'h00;
      sub_code_o <= 8'h00;
    end else begin
      fault_o <= next_fault;
      // lowest numbered active fault is reported first
      if (next_fault[`SHIFS_F_PCHG]) begin
        flash_code_o <= `SHIFS_FLASH_PCHG;
      end else if (next_fault[`SHIFS_F_ILK]) begin
        flash_code_o <= `SHIFS_FLASH_ILK;
      end else if (next_fault[`SHIFS_F_HSW]) begin
        flash_code_o <= `SHIFS_FLASH_HSW;
      end else if (next_fault[`SHIFS_F_NOHOME]) begin
        flash_code_o <= `SHIFS_FLASH_NOHOME;
      end else if (next_fault[`SHIFS_F_HREF]) begin
        flash_code_o <= `SHIFS_FLASH_HREF;
      end else begin
        flash_code_o <= 8'h00;
      end
      // one sub code per flash code here, so any fault reports it
      if (|next_fault) begin
        sub_code_o <= `SHIFS_SUB_CODE;
      end else begin
        sub_code_o <= 8'h00;
      end
    end
  end

  // ****************************************
  // wishbone registers
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      cfg <= `SHIFS_CFG_RST;
      tol <= `SHIFS_TOL_RST;
      tmo <= `SHIFS_TMO_RST;
      irq_mask <= 5'h00;
      pchg_req <= 3'h0;
    end else begin
      // request bits are one-cycle pulses into the fault latch
      pchg_req <= 3'h0;
      if (wr) begin
        case (adr_i)
          `SHIFS_REG_CFG: begin
            cfg <= merge(cfg, dat_i, sel_i);
          end
          `SHIFS_REG_PCHG: begin
            if (sel_i[0]) begin
              pchg_req <= dat_i[2:0];
            end
          end
          `SHIFS_REG_IRQ_MASK: begin
            if (sel_i[0]) begin
              irq_mask <= dat_i[4:0];
            end
          end
          `SHIFS_REG_TOL: begin
            tol <= merge(tol, dat_i, sel_i);
          end
          `SHIFS_REG_TMO: begin
            tmo <= merge(tmo, dat_i, sel_i);
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ****************************************
  // read data and acknowledge
  // ****************************************
  // registered ack: one wait state, and a held strobe is never taken twice
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= bus_req;
      if (rd) begin
        case (adr_i)
          `SHIFS_REG_CFG: begin
            dat_o <= cfg;
          end
          `SHIFS_REG_FAULT: begin
            dat_o <= {27'h0000000, fault_o};
          end
          `SHIFS_REG_CODE: begin
            dat_o <= {16'h0000, sub_code_o, flash_code_o};
          end
          `SHIFS_REG_IRQ_STAT: begin
            dat_o <= {27'h0000000, irq_stat};
          end
          `SHIFS_REG_IRQ_MASK: begin
            dat_o <= {27'h0000000, irq_mask};
          end
          `SHIFS_REG_HOME_POS: begin
            dat_o <= {{(32-POS_W){1'b0}}, home_pos};
          end
          `SHIFS_REG_TOL: begin
            dat_o <= tol;
          end
          `SHIFS_REG_TMO: begin
            dat_o <= tmo;
          end
          default: begin
            dat_o <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // ****************************************
  // interrupt status
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= 5'h00;
    end else if (rd && adr_i == `SHIFS_REG_IRQ_STAT) begin
      // set wins over the clear-on-read, so a new fault is never lost
      irq_stat <= rise;
    end else begin
      irq_stat <= irq_stat | rise;
    end
  end

  assign irq_o = |(irq_stat & irq_mask);

endmodule

//--- shifs_chk_props.sv
/* shifs_chk: port assertions for shifs_supervisor.
   assumes a bind from the bench, one clock domain, sync reset. */
`timescale 1ns/10ps
`include "shifs_map.vh"
// ****************
// checker
// ****************
module shifs_chk (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // bus and interlock
  input wire cyc_i,
  input wire stb_i,
  input wire ack_o,
  input wire interlock_a_i,
  input wire interlock_c_i,
  // fault report
  input wire [4:0] fault_o,
  input wire [7:0] flash_code_o,
  input wire [7:0] sub_code_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held");
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack");
  a_pchg_latch: assert property (fault_o[0] |=> fault_o[0])
    else $error("fault 49 dropped");
  a_home_latch: assert property (|fault_o[4:2] |=> &(fault_o[4:2] | ~$past(fault_o[4:2])))
    else $error("home fault dropped");
  a_ilk_raise: assert property (fault_o[1] |-> $past(interlock_a_i == interlock_c_i))
    else $error("fault 51 without equal inputs");
  a_ilk_clear: assert property ($past(interlock_a_i != interlock_c_i) |-> !fault_o[1])
    else $error("fault 51 kept");
  a_flash_pchg: assert property (fault_o[0] |-> ##[0:1] flash_code_o == `SHIFS_FLASH_PCHG)
    else $error("wrong flash code");
  a_sub_code: assert property (|fault_o |-> ##[0:1] sub_code_o == `SHIFS_SUB_CODE)
    else $error("wrong sub code");
  c_pchg: cover property (fault_o[0]);
  c_ilk: cover property (fault_o[1]);
  c_home: cover property (fault_o[3] || fault_o[4]);
endmodule

//--- shifs_field_model.sv
/* shifs_field: interlock pair, home switch pair and wheel position.
   assumes the bench steers it by nonblocking writes on clk_i. */
`timescale 1ns/10ps
// ****************
// field model
// ****************
module shifs_field (
  // control
  input wire clk_i,
  input wire ilk_ok_i,
  input wire hsw_ok_i,
  input wire hsw_same_i,
  input wire home_lvl_i,
  input wire [15:0] goal_i,
  input wire [15:0] step_i,
  // switches and position
  output reg interlock_a_o,
  output reg interlock_c_o,
  output reg home_sense_a_o,
  output reg home_sense_b_o,
  output reg home_o,
  output reg [15:0] pos_o
);
  initial pos_o = 16'h0000;
  always @(posedge clk_i) begin
    // crossed pair: healthy means opposite levels
    interlock_a_o <= pos_o[0];
    interlock_c_o <= pos_o[0] ^ ilk_ok_i;
    home_o <= home_lvl_i;
    home_sense_a_o <= home_lvl_i;
    home_sense_b_o <= home_lvl_i ^ ~hsw_same_i ^ ~hsw_ok_i;
    // ramp lands on goal exactly, so limits are hit to the count
    if (pos_o + step_i <= goal_i) begin
      pos_o <= pos_o + step_i;
    end else if (pos_o >= goal_i + step_i) begin
      pos_o <= pos_o - step_i;
    end else begin
      pos_o <= goal_i;
    end
  end
endmodule

//--- test_steer_home_interlock_fault_supervisor.sv
/* test_steer_home_interlock_fault_supervisor: random and corner tests.
   assumes shifs_supervisor, shifs_field and shifs_chk are compiled first. */
`timescale 1ns/10ps
`include "shifs_map.vh"
// ****************
// bench
// ****************
module test_steer_home_interlock_fault_supervisor;
  reg clk_i, rst_i, cyc, we, iok, hok, hsm, hl;
  reg [7:0] adr;
  reg [3:0] sel;
  reg [31:0] dat, rd;
  reg [15:0] goal, step, lim;
  reg [2:0] st;
  wire [31:0] dat_o;
  wire [15:0] pos;
  wire [7:0] flash, sub;
  wire [4:0] fault;
  wire ack, irq, ia, ic, ha, hb, hm;
  integer fails, checks, i;
  shifs_field fm_u (.clk_i(clk_i), .ilk_ok_i(iok), .hsw_ok_i(hok), .hsw_same_i(hsm),
    .home_lvl_i(hl), .goal_i(goal), .step_i(step), .interlock_a_o(ia), .interlock_c_o(ic),
    .home_sense_a_o(ha), .home_sense_b_o(hb), .home_o(hm), .pos_o(pos));
  shifs_supervisor #(.TICK_CYC(10)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(cyc), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o),
    .ack_o(ack), .interlock_a_i(ia), .interlock_c_i(ic), .home_sense_a_i(ha),
    .home_sense_b_i(hb), .home_i(hm), .wheel_pos_i(pos), .steer_state_i(st),
    .fault_o(fault), .flash_code_o(flash), .sub_code_o(sub), .irq_o(irq));
  function [7:0] exp_flash(input [4:0] f);
    exp_flash = f[0] ? 8'h31 : f[1] ? 8'h33 : f[2] ? 8'h34 : f[3] ? 8'h35 : f[4] ? 8'h36 : 8'h00;
  endfunction
  task wrap_up;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    checks = checks + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task fchk(input [4:0] e);
    chk("fault", 32'(e), 32'(fault));
    chk("flash", 32'(exp_flash(e)), 32'(flash));
    chk("sub", 32'(|e), 32'(sub));
  endtask
  task tk(input integer n);
    repeat (n) @(posedge clk_i);
  endtask
  task wb(input w, input [7:0] a, input [31:0] d);
    integer n;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    n = 0;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      n = n + 1;
    end
    if (n == 40) begin
      fails = fails + 1;
      wrap_up;
    end
    rd = dat_o;
    cyc <= 1'b0;
  endtask
  task rst_do;
    // power cycle; position ramps home fast meanwhile
    rst_i <= 1'b1;
    st <= 3'h0;
    goal <= 16'h0000;
    step <= 16'h0100;
    tk(16);
    rst_i <= 1'b0;
    iok <= 1'b1;
    hok <= 1'b1;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    {rst_i, cyc, we, iok, hok, hsm, hl} = 7'h40;
    fails = 0;
    checks = 0;
    {adr, dat, goal, step, st} = 'h0;
    rst_i = 1'b1;
    sel = 4'hf;
    i = $urandom(32'h0680);
    rst_do;
    fchk(5'h00);
    wb(0, `SHIFS_REG_TMO, 0);
    chk("tmo", 32'h1388, rd);
    wb(0, 8'h40, 32'hffff_ffff);
    chk("unmapped", 0, rd);
    sel <= 4'h1;
    wb(1, `SHIFS_REG_TOL, 32'hffff_ffff);
    sel <= 4'hf;
    wb(0, `SHIFS_REG_TOL, 0);
    chk("tol", 32'hff, rd);
    $display("test regs done");
    rst_do;
    wb(1, `SHIFS_REG_CFG, 32'h2);
    iok <= 1'b0;
    tk(4);
    fchk(5'h02);
    chk("irq masked", 0, 32'(irq));
    iok <= 1'b1;
    tk(4);
    fchk(5'h00);
    wb(1, `SHIFS_REG_CFG, 32'h0);
    iok <= 1'b0;
    tk(4);
    fchk(5'h00);
    $display("test interlock done");
    for (i = 0; i < 3; i++) begin
      rst_do;
      wb(1, `SHIFS_REG_IRQ_MASK, 32'h1);
      wb(1, `SHIFS_REG_PCHG, 32'h1 << i);
      tk(3);
      fchk(5'h01);
      chk("irq", 1, 32'(irq));
      wb(0, `SHIFS_REG_IRQ_STAT, 0);
      chk("stat", 1, rd);
      tk(1);
      chk("irq cleared", 0, 32'(irq));
    end
    tk(100 + $urandom % 100);
    fchk(5'h01);
    $display("test param change done");
    rst_do;
    wb(1, `SHIFS_REG_TMO, 32'h3);
    st <= 3'h2;
    tk(20);
    fchk(5'h00);
    tk(30);
    fchk(5'h08);
    for (i = 0; i < 2; i++) begin
      lim = i ? `SHIFS_FULL_TRAVEL : `SHIFS_HALF_TRAVEL;
      rst_do;
      wb(1, `SHIFS_REG_CFG, 32'(i) << 4);
      step <= 16'h10 + 16'($urandom % 32);
      st <= 3'h2;
      goal <= lim;
      tk(300);
      fchk(5'h00);
      goal <= lim + 16'h1;
      tk(4);
      fchk(5'h08);
    end
    $display("test homing done");
    for (i = 1; i < 3; i++) begin
      rst_do;
      fchk(5'h00);
      hsm <= (i == 2);
      wb(1, `SHIFS_REG_CFG, 32'(i) << 2);
      step <= 16'h4;
      st <= 3'h2;
      goal <= 16'h0100;
      tk(80);
      hl <= ~hl;
      tk(3);
      st <= 3'h4;
      goal <= 16'h0132;
      tk(20);
      wb(0, `SHIFS_REG_HOME_POS, 0);
      chk("home pos", 32'h0000_0100, rd);
      hl <= ~hl;
      hok <= 1'b0;
      tk(4);
      fchk(5'h00);
      goal <= 16'h0133;
      tk(4);
      fchk(5'h04);
      hl <= ~hl;
      tk(4);
      fchk(5'h14);
      wb(0, `SHIFS_REG_CODE, 0);
      chk("code", 32'h0000_0134, rd);
    end
    $display("test home supervision done");
    wrap_up;
  end
endmodule
bind shifs_supervisor shifs_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .ack_o(ack_o), .interlock_a_i(interlock_a_i), .interlock_c_i(interlock_c_i),
  .fault_o(fault_o), .flash_code_o(flash_code_o), .sub_code_o(sub_code_o));
